// [rtl/cfg_pkg.sv]
// constants and types for power-on configuration sampling
package cfg_pkg;

  // ****************************************************************
  // configuration pin group
  // ****************************************************************
  localparam int          CFG_WIDTH     = 16;
  // upper four pins carry the clock multiplier ratios: no pull-up
  localparam logic [15:0] CFG_PULL_MASK = 16'h0FFF;
  // high level on every bit selects the default setting
  localparam logic [15:0] CFG_RESET_VAL = 16'hFFFF;

  // ****************************************************************
  // timing
  // ****************************************************************
  // platform clocks the pull-up and receiver stay on after the latching edge
  localparam int          HOLD_CLKS     = 4;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_RESET,
    PH_HOLD,
    PH_RUN
  } phase_e;

  typedef struct packed {
    logic release_pin;
    logic pull_en;
    logic rx_en;
  } pad_ctl_s;

endpackage

// [rtl/cfg_pad_cell.sv]
// one shared output pin with configuration input path
`timescale 1ns/10ps
`default_nettype none

module cfg_pad_cell #(
  parameter bit PULLABLE = 1'b1
) (
  input  wire logic              func_out,
  input  wire logic              func_oe_n,
  input  wire logic              pin_in,
  input  wire cfg_pkg::pad_ctl_s ctl,
  output logic                   pin_out,
  output logic                   pin_oe_n,
  output logic                   pin_pull_en,
  output logic                   pin_rx_en,
  output logic                   rx_level
);

  // ****************************************************************
  // pin multiplexing
  // ****************************************************************
  always_comb begin
    // pin stays undriven until it is given back
    pin_out     = ctl.release_pin ? func_out : 1'b0;
    pin_oe_n    = ctl.release_pin ? func_oe_n : 1'b1;
    // pull-up only where the pin has one
    pin_pull_en = PULLABLE & ctl.pull_en;
    pin_rx_en   = ctl.rx_en;
    // receiver disabled reads as low
    rx_level    = ctl.rx_en & pin_in;
  end

endmodule

`default_nettype wire

// [rtl/cfg_sampler.sv]
// power-on configuration capture on shared output pins
// Overview of operation
// [R1] Pins are undriven inputs whenever hard reset is asserted.
// [R2] Pin levels latched on hard reset release, then receiver off, pins back.
// [R3] Gated pull-up on during hard reset and a few clocks after, off with receiver.
// [R4] High sampled level on pulled-up pins means the default setting.
// [R5] Clock multiplier ratio pins have no pull-up; board drives them in reset.
// [R6] Board keeps asynchronous test control pins deasserted in normal operation.
// [R7] Board asserts the test-port reset whenever the device is in reset.
// [R8] Board should assert test-port reset at power-on for reliable startup.
// [R9] Debug probe asserts hard reset and test-port reset independently.
// [R10] Board merges probe resets with all other reset sources by logic.
// [R11] With debug port in use, test-port reset not tied to hard reset; board_model ANDs hard_reset_n into trst_n.
// [R12] Without test use, test-port reset follows hard reset.
// [R13] Unused test clock held statically high.
// [R14] Latched values hold until the next hard reset assertion; rst also loads CFG_RESET_VAL and a new latch follows on release.
`timescale 1ns/10ps
`default_nettype none

module cfg_sampler #(
  parameter int                           WIDTH     = cfg_pkg::CFG_WIDTH,
  parameter logic [cfg_pkg::CFG_WIDTH-1:0] PULL_MASK = cfg_pkg::CFG_PULL_MASK,
  parameter int                           HOLD      = cfg_pkg::HOLD_CLKS
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             hard_reset_n,
  input  wire logic [WIDTH-1:0] func_out,
  input  wire logic [WIDTH-1:0] func_oe_n,
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe_n,
  output logic      [WIDTH-1:0] pad_pu_en,
  output logic      [WIDTH-1:0] pad_rx_en,
  output logic      [WIDTH-1:0] cfg_value,
  output logic                  cfg_valid,
  output logic                  cfg_latched,
  output logic                  pins_released
);

  localparam int CW = $clog2(HOLD + 1);

  // ****************************************************************
  // state
  // ****************************************************************
  cfg_pkg::phase_e   phase_r;
  cfg_pkg::phase_e   phase_nxt;
  logic [CW-1:0]     hold_cnt_r;
  logic [CW-1:0]     hold_cnt_nxt;
  logic [WIDTH-1:0]  cfg_r;
  logic [WIDTH-1:0]  cfg_nxt;
  logic              valid_r;
  logic              valid_nxt;
  logic              latched_r;
  logic              latched_nxt;
  logic [WIDTH-1:0]  rx_level;
  cfg_pkg::pad_ctl_s ctl;

  // ****************************************************************
  // sequencing
  // ****************************************************************
  always_comb begin
    phase_nxt    = phase_r;
    hold_cnt_nxt = hold_cnt_r;
    cfg_nxt      = cfg_r;
    valid_nxt    = valid_r;
    latched_nxt  = 1'b0;
    case (phase_r)
      cfg_pkg::PH_RESET: begin
        valid_nxt = 1'b0;
        if (hard_reset_n) begin
          // capture on release while receivers still listen
          cfg_nxt      = rx_level; // [R2] [R4]
          valid_nxt    = 1'b1;
          latched_nxt  = 1'b1;
          hold_cnt_nxt = '0;
          phase_nxt    = cfg_pkg::PH_HOLD;
        end
      end
      cfg_pkg::PH_HOLD: begin
        if (!hard_reset_n) begin
          phase_nxt = cfg_pkg::PH_RESET; // [R1]
        end else if (hold_cnt_r == CW'(HOLD - 1)) begin
          phase_nxt = cfg_pkg::PH_RUN; // [R3]
        end else begin
          hold_cnt_nxt = hold_cnt_r + CW'(1);
        end
      end
      cfg_pkg::PH_RUN: begin
        // shared pin activity never reaches cfg_r here
        if (!hard_reset_n) begin
          phase_nxt = cfg_pkg::PH_RESET; // [R1] [R14]
        end
      end
      default: begin
        phase_nxt = cfg_pkg::PH_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_r    <= cfg_pkg::PH_RESET;
      hold_cnt_r <= '0;
      cfg_r      <= cfg_pkg::CFG_RESET_VAL[WIDTH-1:0];
      valid_r    <= 1'b0;
      latched_r  <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      cfg_r      <= cfg_nxt;
      valid_r    <= valid_nxt;
      latched_r  <= latched_nxt;
    end
  end

  // ****************************************************************
  // pad control
  // ****************************************************************
  always_comb begin
    // hard reset forces input mode at once, not a clock later
    ctl.release_pin = hard_reset_n & (phase_r == cfg_pkg::PH_RUN); // [R1]
    ctl.rx_en       = ~ctl.release_pin; // [R2]
    ctl.pull_en     = ~ctl.release_pin; // [R3]
  end

  // ****************************************************************
  // pin cells
  // ****************************************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_pad
    cfg_pad_cell #(
      .PULLABLE (PULL_MASK[i]) // [R5]
    ) u_cell (
      .func_out    (func_out[i]),
      .func_oe_n   (func_oe_n[i]),
      .pin_in      (pad_in[i]),
      .ctl         (ctl),
      .pin_out     (pad_out[i]),
      .pin_oe_n    (pad_oe_n[i]),
      .pin_pull_en (pad_pu_en[i]),
      .pin_rx_en   (pad_rx_en[i]),
      .rx_level    (rx_level[i])
    );
  end

  assign cfg_value     = cfg_r;
  assign cfg_valid     = valid_r;
  assign cfg_latched   = latched_r;
  assign pins_released = ctl.release_pin;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_INPUT_IN_RESET: assert property ( // [R1]
    !hard_reset_n |-> (&pad_oe_n && &pad_rx_en)
  ) else $error("pins driven during hard reset");

  AST_LATCH_LEVEL: assert property ( // [R2]
    (phase_r == cfg_pkg::PH_RESET && hard_reset_n)
      |=> (cfg_value == $past(pad_in)) && cfg_valid && cfg_latched
  ) else $error("config not latched from pins at release");

  AST_RETURN_FUNC: assert property ( // [R2]
    (hard_reset_n && phase_r == cfg_pkg::PH_RUN)
      |-> (pad_oe_n == func_oe_n) && (pad_out == func_out)
          && (pad_rx_en == '0)
  ) else $error("pins not returned to normal function");

  AST_PULL_DURING_HOLD: assert property ( // [R3]
    (phase_r != cfg_pkg::PH_RUN || !hard_reset_n)
      |-> (pad_pu_en == PULL_MASK[WIDTH-1:0])
  ) else $error("pull-up off during reset or hold window");

  AST_PULL_OFF_AFTER: assert property ( // [R3]
    (phase_r == cfg_pkg::PH_HOLD && hard_reset_n
      && hold_cnt_r == CW'(HOLD - 1))
      ##1 hard_reset_n
      |-> (pad_pu_en == '0) && (pad_rx_en == '0) && pins_released
  ) else $error("pull-up and receiver not off after hold window");

  AST_HOLD_BOUND: assert property ( // [R3]
    cfg_latched ##1 hard_reset_n [*4]
      |-> (HOLD > 4) || pins_released
  ) else $error("hold window longer than configured");

  AST_DEFAULT_HIGH: assert property ( // [R4]
    (phase_r == cfg_pkg::PH_RESET && hard_reset_n
      && ((pad_in & PULL_MASK[WIDTH-1:0]) == PULL_MASK[WIDTH-1:0]))
      |=> ((cfg_value & PULL_MASK[WIDTH-1:0]) == PULL_MASK[WIDTH-1:0])
  ) else $error("high pulled level did not give default");

  AST_NO_PLL_PULL: assert property ( // [R5]
    (pad_pu_en & ~PULL_MASK[WIDTH-1:0]) == '0
  ) else $error("pull-up enabled on ratio pin");

  AST_HOLD_VALUE: assert property ( // [R14]
    (cfg_valid && $past(cfg_valid) && !cfg_latched) |-> $stable(cfg_value)
  ) else $error("latched config changed without hard reset");

  AST_INVALID_IN_RESET: assert property ( // [R14]
    (!hard_reset_n && phase_r == cfg_pkg::PH_RESET) |=> !cfg_valid
  ) else $error("config still valid during hard reset");

endmodule

`default_nettype wire

// [tb/board_model.sv]
// board pins, straps and reset merging around the sampler
`timescale 1ns/10ps
`default_nettype none
module board_model (
  input  wire logic        clk,
  input  wire logic        sys_rst_n,
  input  wire logic        probe_hrst_n,
  input  wire logic        probe_trst_n,
  input  wire logic [15:0] strap_pd,
  input  wire logic [15:0] strap_drive,
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe_n,
  input  wire logic [15:0] pad_pu_en,
  output logic             hard_reset_n,
  output logic             trst_n,
  output logic             tck,
  output logic [15:0]      pad_in
);
  logic [15:0] last_r;
  // ******
  // resets and test pins
  // ******
  assign hard_reset_n = sys_rst_n & probe_hrst_n;
  assign trst_n = probe_trst_n & hard_reset_n;
  assign tck = 1'b1;
  // ******
  // pin levels
  // ******
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (!cfg_pkg::CFG_PULL_MASK[i]) pad_in[i] = strap_drive[i];
      else if (strap_pd[i]) pad_in[i] = 1'b0;
      else if (pad_pu_en[i]) pad_in[i] = 1'b1;
      else pad_in[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk) last_r <= pad_in;
endmodule
`default_nettype wire

// [tb/reset_config_sampling_and_debug_reset_tb.sv]
// self-checking bench for configuration sampling
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module reset_config_sampling_and_debug_reset_tb;
  localparam int          HOLD = cfg_pkg::HOLD_CLKS;
  localparam logic [15:0] ONES = 16'hFFFF;
  logic        clk = 1'b0, rst = 1'b1, sys_rst_n = 1'b0, probe_hrst_n = 1'b1;
  logic        hard_reset_n, cfg_valid, cfg_latched, pins_released;
  logic [15:0] func_out, func_oe_n, strap_pd, strap_drive, pad_in, pad_out;
  logic [15:0] pad_oe_n, pad_pu_en, pad_rx_en, cfg_value;
  int          err_count, n_compared, seed;
  cfg_sampler uut (.clk(clk), .rst(rst), .hard_reset_n(hard_reset_n),
    .func_out(func_out), .func_oe_n(func_oe_n), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pu_en(pad_pu_en),
    .pad_rx_en(pad_rx_en), .cfg_value(cfg_value), .cfg_valid(cfg_valid),
    .cfg_latched(cfg_latched), .pins_released(pins_released));
  board_model board (.clk(clk), .sys_rst_n(sys_rst_n),
    .probe_hrst_n(probe_hrst_n), .probe_trst_n(1'b1), .strap_pd(strap_pd),
    .strap_drive(strap_drive), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pu_en(pad_pu_en), .hard_reset_n(hard_reset_n), .trst_n(), .tck(),
    .pad_in(pad_in));
  always #5 clk = ~clk;
  // ******
  // helpers
  // ******
  function automatic logic [15:0] exp_cfg(input logic [15:0] pd, drv);
    return (drv & ~cfg_pkg::CFG_PULL_MASK) | (~pd & cfg_pkg::CFG_PULL_MASK);
  endfunction
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic capture(input logic [15:0] pd, drv, input int low);
    int lat_k, rel_k;
    lat_k = 0;
    rel_k = 0;
    strap_pd = pd;
    strap_drive = drv;
    sys_rst_n = 1'b0;
    repeat (low) @(negedge clk);
    `CHK(pad_oe_n, ONES)
    `CHK(pad_rx_en, ONES)
    `CHK(pad_pu_en, cfg_pkg::CFG_PULL_MASK)
    sys_rst_n = 1'b1;
    for (int k = 1; k <= HOLD + 3 && rel_k == 0; k++) begin
      @(negedge clk);
      if (cfg_latched === 1'b1) lat_k = k;
      if (pins_released === 1'b1) rel_k = k;
      else `CHK(pad_pu_en, cfg_pkg::CFG_PULL_MASK)
    end
    if (rel_k == 0) begin
      err_count++;
      $display("ERROR %0t: no release", $time);
      wrap_up();
    end
    `CHK(lat_k, 1)
    `CHK(rel_k > lat_k, 1'b1)
    `CHK(cfg_value, exp_cfg(pd, drv))
    `CHK(cfg_valid, 1'b1)
    `CHK(pad_rx_en | pad_pu_en, 16'h0000)
    repeat (6) begin
      `CHK(pad_oe_n, func_oe_n)
      `CHK(pad_out, func_out)
      `CHK(cfg_value, exp_cfg(pd, drv))
      func_out = 16'($random(seed));
      func_oe_n = 16'($random(seed));
      strap_pd = 16'($random(seed));
      @(negedge clk);
    end
    $display("capture test done");
  endtask
  // ******
  // main sequence
  // ******
  initial begin
    seed = 31607;
    err_count = 0;
    n_compared = 0;
    func_out = 16'h0000;
    func_oe_n = ONES;
    strap_pd = 16'h0000;
    strap_drive = 16'h0000;
    repeat (4) @(negedge clk);
    `CHK(cfg_value, cfg_pkg::CFG_RESET_VAL)
    `CHK(cfg_valid, 1'b0)
    rst = 1'b0;
    capture(16'h0000, 16'h0000, 1);
    capture(ONES, ONES, 3);
    for (int t = 0; t < 10; t++) begin
      capture(16'($random(seed)), 16'($random(seed)),
              1 + ($random(seed) & 3));
    end
    sys_rst_n = 1'b0;
    @(negedge clk);
    sys_rst_n = 1'b1;
    repeat (2) @(negedge clk);
    probe_hrst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(pad_oe_n, ONES)
    `CHK(pins_released, 1'b0)
    `CHK(cfg_valid, 1'b0)
    probe_hrst_n = 1'b1;
    $display("abort test done");
    capture(16'h0F0F, 16'hA000, 2);
    rst = 1'b1;
    @(negedge clk);
    `CHK(cfg_value, cfg_pkg::CFG_RESET_VAL)
    rst = 1'b0;
    @(negedge clk);
    `CHK(cfg_latched, 1'b1)
    `CHK(cfg_value, exp_cfg(strap_pd, strap_drive))
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule
`default_nettype wire
